// File: sbc_host_model.sv
`timescale 1ns/1ps
module sbc_host_model
  import sbc_reset_pkg::*;
(
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int timeouts;

  // Idle bus, address and data scrambled so no stale value looks valid
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h55;
    pwdata = 32'h5555_5555;
    timeouts = 0;
  end

  // One transfer; everything held until pready is sampled high or 20 access-phase edges have passed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeouts++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // Mode write; keep bit carried on every access to stay in dev mode
  task automatic mode_write(input logic keep);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, MODE_OFS, {31'h0, keep}, rd, err);
    // One more edge so the mode change is visible to the caller
    @(posedge core_clk);
  endtask

  // Init bit write, only meaningful inside the start-up window
  task automatic init_write();
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, SPEC_OFS, 32'h1, rd, err);
    // One more edge so the mode change is visible to the caller
    @(posedge core_clk);
  endtask
endmodule

// File: sbc_reset_bank.sv
`timescale 1ns/1ps
module sbc_reset_bank
  import sbc_reset_pkg::*;
#(
  parameter int             INT_W     = 8,
  parameter logic [3:0]     MASK_VER  = 4'h1,  // Arbitrary value
  parameter logic [6:0]     CHIP_TYPE = 7'h2a  // Arbitrary value
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Mode entries as one-cycle pulses, then current mode levels
  input  wire logic              enterStartup,
  input  wire logic              enterRestart,
  input  wire logic              enterFailsafe,
  input  wire logic              inStartup,
  input  wire logic              inStandbySleep,
  // Live status
  input  wire logic [1:0]        busFailureDiag,
  input  wire logic              auxSupplyDiag,
  input  wire logic              coreSupplyDiag,
  input  wire logic [INT_W-1:0]  intEvent,
  // Watchdog and fail-safe causes, pulses
  input  wire logic              wdOverflow,
  input  wire logic              wdWindowMiss,
  input  wire logic              intTimeout,
  input  wire logic              startupExpired,
  input  wire logic [3:0]        wdResetSource,
  input  wire logic              failsafeCause,
  input  wire logic              coreUvClamp,
  // Test straps, sampled once after reset release; reset pin level used live
  input  wire logic              testPreBattery,
  input  wire logic              testAtBattery,
  input  wire logic              resetPinLevel,
  // Results
  output logic                   sysResetReq,
  output logic                   failsafeReq,
  output logic                   devModeActive,
  output logic                   forcedNormal,
  output logic                   watchdogEnable,
  output logic                   longResetStart,
  output logic                   auxRegOn,
  output logic                   busActiveForce,
  output logic                   limpHomeOutput,
  output logic                   systemInhibitOutput,
  output logic                   enableOut
);

  logic [3:0]       diag_q;
  logic [INT_W-1:0] intEn_q;
  logic [INT_W-1:0] intPend_q;
  logic [7:0]       sysCfg_q;
  logic [3:0]       phy_q;
  logic [4:0]       spec_q;
  logic [11:0]      gp0_q;
  logic [11:0]      gp1_q;
  logic [3:0]       srcCode_q;
  logic             live_q;
  logic             strapDone_q;
  logic             devMode_q;
  logic             devUsed_q;
  logic             forced_q;
  logic             ready_q;
  logic [31:0]      rdata_q;
  logic             err_q;

  // APB decode; writes land on the edge that completes the transfer
  wire        access  = psel & penable & ~ready_q;
  wire        done    = psel & penable & ready_q;
  wire        mapped  = (paddr <= STAT_OFS) && (paddr[1:0] == 2'b00);
  wire        wrOk    = done & pwrite & mapped & ~forced_q;  // R18
  wire        wrInten = wrOk & (paddr == INTEN_OFS);
  wire        wrIntpd = wrOk & (paddr == INTPD_OFS);
  wire        wrCfg   = wrOk & (paddr == SYSCFG_OFS);
  wire        wrPhy   = wrOk & (paddr == PHY_OFS);
  wire        wrSpec  = wrOk & (paddr == SPEC_OFS);
  wire        wrGp0   = wrOk & (paddr == GP0_OFS);
  wire        wrGp1   = wrOk & (paddr == GP1_OFS);
  wire        wrMode  = wrOk & (paddr == MODE_OFS);
  wire        clrPend = enterStartup | enterRestart;

  // Development mode gating of watchdog, interrupt timeout and start-up expiry resets, and of fail-safe
  wire        dmGate  = devMode_q & ~inStandbySleep;  // R12
  wire        wdEvent = wdOverflow | wdWindowMiss;
  wire        rstCause = wdEvent | intTimeout | startupExpired;
  wire        fsLive  = coreUvClamp | (failsafeCause & ~devMode_q & ~forced_q);
  wire        isdmSet = wrSpec & pwdata[DEVMODE_INIT_BIT_BIT] & inStartup & ~devUsed_q;

  // Read mux, reserved bits read as zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      DIAG_OFS:   rdMux[3:0] = diag_q;
      INTEN_OFS:  rdMux[INT_W-1:0] = intEn_q;
      INTPD_OFS:  rdMux[INT_W-1:0] = intPend_q;
      SYSCFG_OFS: rdMux[7:0] = sysCfg_q;
      PHY_OFS:    rdMux[3:0] = phy_q;
      SPEC_OFS:   rdMux[4:0] = spec_q;
      GP0_OFS:    rdMux[11:0] = gp0_q;
      GP1_OFS:    rdMux[11:0] = gp1_q;
      MODE_OFS:   rdMux[KEEP_BIT] = devMode_q;
      STAT_OFS:   rdMux[5:0] = {forced_q, devMode_q, srcCode_q};
      default:    rdMux = 32'h0000_0000;
    endcase
  end

  // Bus answer: ready one cycle into the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      ready_q <= access;
      rdata_q <= (access & ~forced_q) ? rdMux : 32'h0000_0000;  // R18
      err_q   <= access & (~mapped | forced_q);  // R18
    end
  end

  // Diagnosis: por values, then live after start-up or restart
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_q <= DIAG_POR;  // R1
      live_q <= 1'b0;
    end else begin
      if (clrPend) begin
        live_q <= 1'b1;
      end
      if (clrPend | live_q) begin
        diag_q <= {coreSupplyDiag, auxSupplyDiag, busFailureDiag};  // R1
      end
    end
  end

  // Interrupt enable and pending; event set beats a software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intEn_q   <= '0;  // R2
      intPend_q <= '0;  // R3
    end else begin
      if (wrInten) begin
        intEn_q <= pwdata[INT_W-1:0];  // R2
      end
      if (clrPend) begin
        intPend_q <= '0;  // R3
      end else begin
        intPend_q <= (intPend_q & ~(wrIntpd ? pwdata[INT_W-1:0] : '0))
                     | (intEvent & intEn_q);
      end
    end
  end

  // System configuration with entry overrides ahead of writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysCfg_q <= SYSCFG_POR;  // R4 R5
    end else if (enterFailsafe) begin
      sysCfg_q[RLS_BIT] <= 1'b1;  // R4 R23
      sysCfg_q[LEN_BIT] <= 1'b1;  // R5
      sysCfg_q[LLV_BIT] <= 1'b0;  // R5
    end else if (enterRestart) begin
      sysCfg_q[RLS_BIT] <= 1'b1;  // R4 R23
      if (sysCfg_q[LLV_BIT]) begin
        sysCfg_q[LEN_BIT] <= 1'b0;  // R5
      end
    end else if (wrCfg & ~enterStartup) begin
      sysCfg_q <= pwdata[7:0];
    end
  end

  // Physical layer, special mode, general words
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_q <= PHY_POR;  // R6
      spec_q <= SPEC_POR;  // R7
      gp0_q <= {1'b0, MASK_VER, CHIP_TYPE};  // R8
      gp1_q <= GP1_POR;  // R9
    end else begin
      if (wrPhy) begin
        phy_q <= pwdata[3:0];  // R6
      end
      if (enterRestart) begin
        spec_q <= spec_q & ~THR_MASK;  // R7 R23
      end else if (wrSpec) begin
        spec_q <= pwdata[4:0];
      end
      if (wrGp0) begin
        gp0_q <= pwdata[11:0] | 12'h800;  // R22
      end
      if (wrGp1) begin
        gp1_q <= pwdata[11:0];  // R9
      end
    end
  end

  // Test modes: straps caught once, then bus entry and exit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDone_q <= 1'b0;
      devMode_q   <= 1'b0;
      devUsed_q   <= 1'b0;
      forced_q    <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      devMode_q   <= testPreBattery;  // R15
      devUsed_q   <= testPreBattery;
      forced_q    <= testAtBattery;  // R21
    end else if (wrMode & ~pwdata[KEEP_BIT]) begin
      devMode_q <= 1'b0;  // R17
      devUsed_q <= 1'b1;
    end else if (isdmSet) begin
      devMode_q <= 1'b1;  // R14
      devUsed_q <= 1'b1;
    end
  end

  // Reset source recording is kept when development mode holds the reset off, not in forced normal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcCode_q <= SRC_POR;
    end else if (wdEvent & ~forced_q) begin
      srcCode_q <= wdResetSource;  // R11
    end
  end

  // System outputs, all registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysResetReq         <= 1'b0;
      failsafeReq         <= 1'b0;
      watchdogEnable      <= 1'b0;
      longResetStart      <= 1'b0;
      auxRegOn            <= 1'b0;
      busActiveForce      <= 1'b0;
      limpHomeOutput      <= 1'b0;
      systemInhibitOutput <= 1'b0;
      enableOut           <= 1'b0;
    end else begin
      sysResetReq    <= rstCause & ~dmGate & ~forced_q;  // R10 R18
      failsafeReq    <= fsLive;  // R13 R19
      watchdogEnable <= strapDone_q & ~forced_q;  // R18
      longResetStart <= forced_q | sysCfg_q[RLS_BIT];  // R19
      auxRegOn       <= forced_q | (sysCfg_q[2:1] != 2'b00);  // R20
      busActiveForce <= forced_q;  // R20
      limpHomeOutput <= forced_q
                        | (sysCfg_q[LEN_BIT] & sysCfg_q[LLV_BIT]);  // R20
      systemInhibitOutput <= forced_q;  // R20
      enableOut      <= forced_q & resetPinLevel;  // R20
    end
  end

  assign prdata        = rdata_q;
  assign pready        = ready_q;
  assign pslverr       = err_q;
  assign devModeActive = devMode_q;
  assign forcedNormal  = forced_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence startupEntry;
    strapDone_q && enterStartup;
  endsequence
  sequence restartEntry;
    strapDone_q && enterRestart && !enterFailsafe;
  endsequence

  pend_clear_a: assert property ( // R3
    (startupEntry or restartEntry) |=> intPend_q == '0)
    else $error("pending flags not cleared on entry");
  cfg_restart_a: assert property ( // R4
    restartEntry |=> sysCfg_q[RLS_BIT])
    else $error("reset length not long after restart");
  limp_fs_a: assert property ( // R5
    enterFailsafe |=> sysCfg_q[LEN_BIT] && !sysCfg_q[LLV_BIT])
    else $error("limp not driven low after fail-safe");
  thr_restart_a: assert property ( // R7
    enterRestart |=> spec_q[4:3] == 2'b00 && spec_q[2:0] == $past(spec_q[2:0]))
    else $error("threshold restart handling wrong");
  dev_reset_a: assert property ( // R10
    devMode_q && !inStandbySleep && rstCause |=> !sysResetReq)
    else $error("reset not suppressed in development mode");
  src_keep_a: assert property ( // R11
    wdEvent && !forced_q |=> srcCode_q == $past(wdResetSource))
    else $error("reset source not recorded");
  fs_block_a: assert property ( // R13
    devMode_q && failsafeCause && !coreUvClamp |=> !failsafeReq)
    else $error("fail-safe not blocked");
  dev_once_a: assert property ( // R17
    devUsed_q && !devMode_q |=> !devMode_q)
    else $error("development mode re-entered");
  forced_bus_a: assert property ( // R18
    forced_q && access |=> err_q && rdata_q == 32'h0000_0000)
    else $error("access not blocked in forced normal");
  forced_out_a: assert property ( // R20
    forced_q ##1 forced_q |-> limpHomeOutput && systemInhibitOutput
      && auxRegOn && busActiveForce)
    else $error("forced normal outputs wrong");
  gp0_dic_a: assert property ( // R22
    wrGp0 |=> gp0_q[DIC_BIT])
    else $error("ident bit not set by write");

  // Entry values and what each entry must leave alone
  diag_por_a: assert property ( // R1
    !live_q && !clrPend |=> diag_q == DIAG_POR)
    else $error("diagnosis left power-on value early");
  diag_live_a: assert property ( // R1
    clrPend || live_q |=>
      diag_q == $past({coreSupplyDiag, auxSupplyDiag, busFailureDiag}))
    else $error("diagnosis not tracking live status");
  inten_keep_a: assert property ( // R2
    clrPend && !wrInten |=> $stable(intEn_q))
    else $error("interrupt enables changed on entry");
  pend_set_a: assert property ( // R3
    !clrPend && (intEvent & intEn_q) != '0 |=>
      (intPend_q & $past(intEvent & intEn_q)) == $past(intEvent & intEn_q))
    else $error("enabled event lost");
  cfg_start_a: assert property ( // R4
    strapDone_q && enterStartup && !enterRestart && !enterFailsafe
      |=> $stable(sysCfg_q))
    else $error("configuration changed on start-up");
  limp_restart_a: assert property ( // R5
    enterRestart && !enterFailsafe |=>
      sysCfg_q[LEN_BIT] == ($past(sysCfg_q[LEN_BIT])
                            && !$past(sysCfg_q[LLV_BIT])))
    else $error("limp enable restart handling wrong");
  phy_keep_a: assert property ( // R6
    !wrPhy |=> $stable(phy_q))
    else $error("physical layer control changed without write");
  spec_keep_a: assert property ( // R7
    !enterRestart && !wrSpec |=> $stable(spec_q))
    else $error("special mode changed without cause");
  gp0_keep_a: assert property ( // R8
    !wrGp0 |=> $stable(gp0_q))
    else $error("general word zero changed without write");
  gp1_keep_a: assert property ( // R9
    !wrGp1 |=> $stable(gp1_q))
    else $error("general word one changed without write");

  // Development mode gating, entry and exit
  src_hold_a: assert property ( // R11
    !(wdEvent && !forced_q) |=> $stable(srcCode_q))
    else $error("reset source changed without trigger failure");
  dev_standby_a: assert property ( // R12
    devMode_q && inStandbySleep && rstCause && !forced_q |=> sysResetReq)
    else $error("reset suppressed in standby or sleep");
  fs_clamp_a: assert property ( // R13
    coreUvClamp |=> failsafeReq)
    else $error("clamp undervoltage did not request fail-safe");
  dev_entry_a: assert property ( // R14
    strapDone_q && !devMode_q && !isdmSet |=> !devMode_q)
    else $error("development mode entered without init bit");
  strap_catch_a: assert property ( // R15
    !strapDone_q |=> devMode_q == $past(testPreBattery)
      && forced_q == $past(testAtBattery))
    else $error("test straps not captured");
  dev_exit_a: assert property ( // R17
    strapDone_q && wrMode && !pwdata[KEEP_BIT] |=> !devMode_q)
    else $error("development mode not left on keep bit 0");

  // Forced normal: monitors off, registers frozen, enable follows reset
  wd_enable_a: assert property ( // R18
    strapDone_q && !forced_q |=> watchdogEnable)
    else $error("watchdog not enabled outside forced normal");
  forced_off_a: assert property ( // R18
    forced_q |=> !sysResetReq && !watchdogEnable)
    else $error("monitor active in forced normal");
  forced_wr_a: assert property ( // R18
    forced_q |=> $stable(gp1_q) && $stable(phy_q))
    else $error("register written in forced normal");
  enable_follow_a: assert property ( // R20
    forced_q |=> enableOut == $past(resetPinLevel))
    else $error("enable pin not following reset pin");

endmodule

// File: sbc_reset_pkg.sv
// Contract
// R1 - Power-on: bus failure 00, aux diag 1, core diag 0; live in start/restart
// R2 - Interrupt enables clear on power-on, kept on start-up and restart
// R3 - Pending interrupts clear on power-on, start-up and restart entry
// R4 - Config defaults on power-on; reset length long on restart and fail-safe
// R5 - Limp enable/level 0 on power-on; restart floats if level 1; fail-safe drives
// R6 - Bus physical controls clear on power-on, kept on every other entry
// R7 - Power-on clears init bit, prescale, threshold; restart clears threshold only
// R8 - Power-on clears ident bit, loads version and chip type in word zero
// R9 - Second general word clears on power-on, kept on start-up and restart
// R10 - Development mode suppresses watchdog, interrupt timeout, start-up expiry resets
// R11 - Trigger failure still records its reset source in development mode
// R12 - Development mode ignored for watchdog in standby and sleep
// R13 - Development mode blocks fail-safe except long core undervoltage
// R14 - Init bit enters development mode once, only in start-up after power-on
// R15 - Test level before battery enters development mode
// R16 - Host keeps keep bit set in every mode write to stay
// R17 - Keep bit written 0 leaves; re-entry only after new power-on
// R18 - Forced normal blocks bus access and disables watchdog and monitors
// R19 - Forced normal starts long reset; clamp overload enters fail-safe
// R20 - Forced normal: aux on, bus active, limp and inhibit high, enable follows reset
// R21 - Test level at first battery connection activates forced normal
// R22 - Any write to word zero sets the ident bit
// R23 - Entry reset values apply in the entry cycle, ahead of bus writes
package sbc_reset_pkg;
  // Word offsets of the register map
  localparam logic [7:0] DIAG_OFS   = 8'h00;
  localparam logic [7:0] INTEN_OFS  = 8'h04;
  localparam logic [7:0] INTPD_OFS  = 8'h08;
  localparam logic [7:0] SYSCFG_OFS = 8'h0c;
  localparam logic [7:0] PHY_OFS    = 8'h10;
  localparam logic [7:0] SPEC_OFS   = 8'h14;
  localparam logic [7:0] GP0_OFS    = 8'h18;
  localparam logic [7:0] GP1_OFS    = 8'h1c;
  localparam logic [7:0] MODE_OFS   = 8'h20;
  localparam logic [7:0] STAT_OFS   = 8'h24;
  // Field positions
  localparam int RLS_BIT  = 0;
  localparam int LEN_BIT  = 6;
  localparam int LLV_BIT  = 7;
  localparam int DEVMODE_INIT_BIT_BIT = 0;
  localparam int KEEP_BIT = 0;
  localparam int DIC_BIT  = 11;
  // Reset values
  localparam logic [3:0]  DIAG_POR   = 4'h4;
  localparam logic [7:0]  SYSCFG_POR = 8'h10;
  localparam logic [3:0]  PHY_POR    = 4'h0;
  localparam logic [4:0]  SPEC_POR   = 5'h00;
  localparam logic [4:0]  THR_MASK   = 5'h18;
  localparam logic [11:0] GP1_POR    = 12'h000;
  localparam logic [3:0]  SRC_POR    = 4'h0;
endpackage

// File: sbc_reset_values_and_test_modes_tb.sv
`timescale 1ns/1ps
module sbc_reset_values_and_test_modes_tb
  import sbc_reset_pkg::*;
;
  localparam logic [3:0] MV = 4'h1;  // Arbitrary value
  localparam logic [6:0] CT = 7'h2a; // Arbitrary value
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, intEvent;
  logic [31:0] pwdata, prdata, r, rd;
  logic [2:0]  entry;
  logic [4:0]  ev;
  logic [3:0]  wdSrc, diagIn;
  logic        inStartup, inSb, coreUv, tPre, tAt, rstPin, err;
  logic        sysRst, fsReq, devOn, forced, wdEn, longRst, aux, busAct;
  logic        limp, inhibit, enOut, rstSeen, fsSeen;
  int          failures, nChecks, cycles;
  int          mdl[10];
  int          msk[10] = '{'hf, 'hff, 'hff, 'hff, 'hf, 'h1f, 'hfff, 'hfff,
                           'h1, 'h3f};

  sbc_host_model hostU (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  sbc_reset_bank #(.INT_W(8), .MASK_VER(MV), .CHIP_TYPE(CT)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enterStartup(entry[0]),
    .enterRestart(entry[1]), .enterFailsafe(entry[2]),
    .inStartup(inStartup), .inStandbySleep(inSb),
    .busFailureDiag(diagIn[1:0]), .auxSupplyDiag(diagIn[2]),
    .coreSupplyDiag(diagIn[3]), .intEvent(intEvent),
    .wdOverflow(ev[0]), .wdWindowMiss(ev[1]), .intTimeout(ev[2]),
    .startupExpired(ev[3]), .wdResetSource(wdSrc), .failsafeCause(ev[4]),
    .coreUvClamp(coreUv), .testPreBattery(tPre), .testAtBattery(tAt),
    .resetPinLevel(rstPin), .sysResetReq(sysRst), .failsafeReq(fsReq),
    .devModeActive(devOn), .forcedNormal(forced), .watchdogEnable(wdEn),
    .longResetStart(longRst), .auxRegOn(aux), .busActiveForce(busAct),
    .limpHomeOutput(limp), .systemInhibitOutput(inhibit),
    .enableOut(enOut));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Sticky flags catch one-cycle requests; the cycle cap cuts a hang
  always @(posedge core_clk) begin
    cycles++;
    if (sysRst === 1'b1) rstSeen = 1'b1;
    if (fsReq === 1'b1) fsSeen = 1'b1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    failures += hostU.timeouts;
    if (failures == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input int i);
    hostU.xfer(1'b0, 8'(i * 4), 32'h0, rd, err);
    chk(rd & msk[i], mdl[i]);
  endtask

  // Write and mirror into the reference image
  task automatic wr(input int i, input logic [31:0] d);
    hostU.xfer(1'b1, 8'(i * 4), d, rd, err);
    if (i == 2) mdl[2] &= ~d;
    else if (i == 6) mdl[6] = (d & 'h7ff) | 'h800;
    else mdl[i] = d & msk[i];
  endtask

  // Straps are held across release so the first edge captures them
  task automatic do_reset(input logic pre, input logic at);
    rst_n <= 1'b0;
    tPre <= pre;
    tAt <= at;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    mdl = '{'h4, 0, 0, 'h10, 0, 0, {MV, CT}, 0, 0, 0};
  endtask

  // Mode entry pulse and its expected effect on the image
  task automatic enter(input int k);
    entry <= 3'(1 << k);
    @(posedge core_clk);
    entry <= 3'h0;
    repeat (3) @(posedge core_clk);
    if (k < 2) mdl[0] = diagIn;
    if (k < 2) mdl[2] = 0;
    if (k == 1) begin
      mdl[3] |= 1;
      if (mdl[3][7]) mdl[3] &= ~'h40;
      mdl[5] &= ~'h18;
    end
    if (k == 2) mdl[3] = (mdl[3] | 'h41) & ~'h80;
  endtask

  task automatic event_pulse(input int k, input logic [3:0] src);
    wdSrc <= src;
    ev <= 5'(1 << k);
    @(posedge core_clk);
    ev <= 5'h0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic ints();
    intEvent <= 8'hff;
    @(posedge core_clk);
    intEvent <= 8'h0;
    repeat (3) @(posedge core_clk);
    mdl[2] |= mdl[1];
  endtask

  initial begin
    rst_n = 1'b0;
    {entry, ev, wdSrc, intEvent, diagIn} = '0;
    {inStartup, inSb, coreUv, tPre, tAt, rstPin} = '0;
    {failures, nChecks, cycles} = '0;
    void'($urandom(70645));
    do_reset(1'b0, 1'b0);
    chk({forced, wdEn}, 2'b01);
    for (int i = 0; i < 8; i++) rd_chk(i);
    r = $urandom;
    diagIn <= 4'($urandom);
    wr(1, r);
    wr(3, (r & 'h3e) | 'hc0);
    wr(4, r);
    wr(5, (r & 'h1e) | 'h18);
    wr(6, r & ~'h800);
    wr(7, r);
    ints();
    chk(limp, 1'b1);
    for (int i = 1; i < 8; i++) rd_chk(i);
    enter(0);
    for (int i = 0; i < 8; i++) rd_chk(i);
    ints();
    enter(1);
    chk({longRst, limp}, 2'b10);
    for (int i = 0; i < 8; i++) rd_chk(i);
    enter(2);
    for (int i = 3; i < 5; i++) rd_chk(i);
    hostU.xfer(1'b0, 8'h28, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    rstSeen = 1'b0;
    event_pulse(0, 4'h3);
    chk(rstSeen, 1);
    fsSeen = 1'b0;
    event_pulse(4, 4'h0);
    chk(fsSeen, 1);
    // Development mode through the init bit inside start-up
    inStartup <= 1'b1;
    hostU.init_write();
    chk(devOn, 1);
    rstSeen = 1'b0;
    for (int k = 0; k < 4; k++) event_pulse(k, 4'(k + 8));
    chk(rstSeen, 0);
    hostU.xfer(1'b0, STAT_OFS, 32'h0, rd, err);
    chk(rd[4:0], 5'h19);
    inSb <= 1'b1;
    event_pulse(0, 4'h3);
    chk(rstSeen, 1);
    inSb <= 1'b0;
    hostU.mode_write(1'b1);
    chk(devOn, 1);
    fsSeen = 1'b0;
    event_pulse(4, 4'h0);
    chk(fsSeen, 0);
    coreUv <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(fsSeen, 1);
    coreUv <= 1'b0;
    hostU.mode_write(1'b0);
    chk(devOn, 0);
    hostU.init_write();
    chk(devOn, 0);
    inStartup <= 1'b0;
    do_reset(1'b1, 1'b0);
    chk(devOn, 1);
    do_reset(1'b0, 1'b1);
    chk({forced, wdEn}, 2'b10);
    chk({longRst, aux, busAct, limp, inhibit}, 5'h1f);
    hostU.xfer(1'b0, DIAG_OFS, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      rstPin <= ~rstPin;
      repeat (3) @(posedge core_clk);
      chk(enOut, rstPin);
    end
    print_verdict();
  end
endmodule
